// File: src/mcr_consts.svh
// offsets, field positions, reset values for the msi/error config registers
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MCR_OFF_XADDR  12'h0E0
`define MCR_OFF_XDATA  12'h0E4
`define MCR_OFF_RSV0   12'h0E8
`define MCR_OFF_RSV1   12'h0EC
`define MCR_OFF_MSI    12'h0F0
`define MCR_OFF_MADDR  12'h0F4
`define MCR_OFF_MUPPER 12'h0F8
`define MCR_OFF_MDATA  12'h0FC
`define MCR_OFF_AER    12'h100
`define MCR_OFF_UEFLAG 12'h104
`define MCR_OFF_UEMASK 12'h108
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MCR_XEN_BIT    31
`define MCR_XADDR_RW   32'h8FFF_FFFF
`define MCR_MSI_CAPABILITY_ID     8'h05
`define MCR_MSI_NEXT   8'h00
`define MCR_MSIEN_BIT  16
`define MCR_MMC_RST    3'h0
`define MCR_MME_RST    3'h0
`define MCR_CAP64_RST  1'h1
`define MCR_MADDR_RW   32'hFFFF_FFFC
`define MCR_AER_ID     16'h0001
`define MCR_AER_VER    4'h1
`define MCR_AER_NEXT   12'h150
`define MCR_UE_IMPL    32'h001F_F011
`define MCR_SYNC_DEPTH 3
`endif

// File: src/mcr_pkg.sv
// types shared by the msi/error config register block
package mcr_pkg;
    // configuration request from the host side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } mcr_cfg_req_type;

    // outbound message write
    typedef struct packed {
        logic [63:0] addr;
        logic [15:0] data;
        logic        dual;
    } mcr_msi_wr_type;

    typedef enum logic [0:0] {
        MCR_IDLE = 1'b0,
        MCR_SEND = 1'b1
    } mcr_msi_state_type;

    // byte-enable merge of a write into an old word
    function automatic logic [31:0] mcr_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_w & ~m) | (new_w & m);
    endfunction
endpackage

// File: src/mcr_err_flags.sv
// sticky write-one-to-clear error flags
`timescale 1ns/1ps
`include "mcr_consts.svh"
module mcr_err_flags
    import mcr_pkg::*;
#(
    parameter int          W    = 32,
    parameter logic [31:0] IMPL = `MCR_UE_IMPL
) (
    // clock and power-on reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // events and clears
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    // flag state
    output logic      [W-1:0] flag_q
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    // set wins over a clear in the same cycle; only implemented bits exist
    assign flag_next = ((flag_reg & ~clr_in) | set_in) & IMPL[W-1:0];
    assign flag_q    = flag_reg;

    // sticky: only the power-on reset clears these
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule // mcr_err_flags

// File: src/mcr_msi_sender.sv
// issues one message write per interrupt condition
`timescale 1ns/1ps
module mcr_msi_sender
    import mcr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    // programming
    input  wire logic        enable,
    input  wire logic        cap64,
    input  wire logic [31:0] addr_lo,
    input  wire logic [31:0] addr_hi,
    input  wire logic [15:0] data,
    // interrupt condition
    input  wire logic        trigger,
    // write channel
    output mcr_msi_wr_type   msi_wr,
    output logic             msi_valid,
    input  wire logic        msi_ready
);
    mcr_msi_state_type state_reg;
    mcr_msi_state_type state_next;
    mcr_msi_wr_type    wr_reg;
    mcr_msi_wr_type    wr_next;
    logic              pend_reg;
    logic              pend_next;
    logic              use_hi;
    logic              done;

    // upper half only counts when the 64-bit form is on and it is nonzero
    assign use_hi    = cap64 && (addr_hi != 32'h0000_0000);
    assign done      = (state_reg == MCR_SEND) && msi_ready;
    assign msi_valid = (state_reg == MCR_SEND) && enable;
    assign msi_wr    = wr_reg;
    assign wr_next   = '{addr: {use_hi ? addr_hi : 32'h0000_0000, addr_lo},
                         data: data, dual: use_hi};

    // a condition seen mid-send is kept pending, even in the retire cycle; disable clears both
    always_comb begin
        state_next = state_reg;
        pend_next  = pend_reg;
        unique case (state_reg)
            MCR_IDLE: begin
                if (enable && (trigger || pend_reg)) begin
                    state_next = MCR_SEND;
                    pend_next  = 1'b0;
                end
            end
            MCR_SEND: begin
                if (trigger) begin
                    pend_next = 1'b1;
                end
                if (done) begin
                    state_next = MCR_IDLE;
                end
            end
        endcase
        if (!enable) begin
            state_next = MCR_IDLE;
            pend_next  = 1'b0;
        end
    end

    // state and payload, payload latched when a send starts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= MCR_IDLE;
            pend_reg  <= 1'b0;
            wr_reg    <= '0;
        end else if (soft_rst) begin
            state_reg <= MCR_IDLE;
            pend_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg  <= pend_next;
            if (state_reg == MCR_IDLE && state_next == MCR_SEND) begin
                wr_reg <= wr_next;
            end
        end
    end
endmodule // mcr_msi_sender

// File: src/mcr_cfg_regs.sv
// msi capability, error reporting header and error status/mask registers
// Behaviour
// - data port at E4h, read-write, resets to zero
// - port forwards extended access only while address bit 31 is set
// - E8h and ECh are reserved, read zero, ignore writes
// - F0h bits 7:0 read 05h, the msi capability id
// - F0h bits 15:8 read 00h, end of capability list
// - enable clear: no messages, legacy interrupt line used
// - enable set: messages used, legacy interrupt pin ignored
// - message-count capability bits 19:17 read-only, zero
// - enabled-count bits 22:20 writable; software avoids codes 110, 111
// - bit 23 64-bit indicator resets to 1; bits 31:24 read zero
// - message address bits 31:2 at F4h; bits 1:0 read zero
// - upper message address at F8h, resets to zero
// - message data bits 15:0 at FCh; bits 31:16 read zero
// - 100h bits 15:0 read 0001h
// - 100h bits 19:16 read version 1h
// - 100h bits 31:20 read next offset 150h
// - sticky write-one-clear error flags at 104h, reset zero
// - sticky error masks at 108h, same bits, reserved read zero
`timescale 1ns/1ps
`include "mcr_consts.svh"
module mcr_cfg_regs
    import mcr_pkg::*;
(
    // clock and resets
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cfg_soft_rst,
    // configuration request and answer
    input  mcr_cfg_req_type  cfg_req,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    // extended configuration access
    output logic             ext_wr,
    output logic             ext_rd,
    output logic [27:0]      ext_addr,
    output logic [31:0]      ext_wdata,
    output logic [3:0]       ext_be,
    input  wire logic [31:0] ext_rdata,
    // interrupts
    input  wire logic        irq_event,
    input  wire logic        intx_pin_n,
    output logic             intx_out_n,
    output mcr_msi_wr_type   msi_wr,
    output logic             msi_valid,
    input  wire logic        msi_ready,
    // error events
    input  wire logic [31:0] err_event,
    output logic             err_report
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] xaddr_reg;
    logic [31:0] xdata_reg;
    logic        msien_reg;
    logic [2:0]  mme_reg;
    logic        cap64_reg;
    logic [31:0] maddr_reg;
    logic [31:0] mupper_reg;
    logic [15:0] mdata_reg;
    logic [31:0] mask_reg;
    logic [31:0] flags;
    logic [`MCR_SYNC_DEPTH-1:0] intx_sync_reg;
    logic        intx_f_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        ext_wr_reg;
    logic        ext_rd_reg;
    logic [31:0] ext_wdata_reg;
    logic [3:0]  ext_be_reg;
    logic        rep_reg;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire req_wr   = cfg_req.valid && cfg_req.write;
    wire req_rd   = cfg_req.valid && !cfg_req.write;
    wire hit_xa   = cfg_req.addr == `MCR_OFF_XADDR;
    wire hit_xd   = cfg_req.addr == `MCR_OFF_XDATA;
    wire hit_msi  = cfg_req.addr == `MCR_OFF_MSI;
    wire hit_ma   = cfg_req.addr == `MCR_OFF_MADDR;
    wire hit_mu   = cfg_req.addr == `MCR_OFF_MUPPER;
    wire hit_md   = cfg_req.addr == `MCR_OFF_MDATA;
    wire hit_aer  = cfg_req.addr == `MCR_OFF_AER;
    wire hit_uf   = cfg_req.addr == `MCR_OFF_UEFLAG;
    wire hit_um   = cfg_req.addr == `MCR_OFF_UEMASK;
    wire xen      = xaddr_reg[`MCR_XEN_BIT];
    wire [31:0] be_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
                           {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

    // ----------------------------------------
    // read views
    // ----------------------------------------
    // next pointer zero
    wire [31:0] msi_word = {8'h00, cap64_reg, mme_reg, `MCR_MMC_RST,
                            msien_reg, `MCR_MSI_NEXT, `MCR_MSI_CAPABILITY_ID};
    wire [31:0] aer_word = {`MCR_AER_NEXT, `MCR_AER_VER, `MCR_AER_ID};

    // reserved and unmapped offsets fall through to zero
    wire [31:0] rd_word =
        hit_xa  ? xaddr_reg :
        hit_xd  ? (xen ? ext_rdata : xdata_reg) :
        hit_msi ? msi_word :
        hit_ma  ? maddr_reg :
        hit_mu  ? mupper_reg :
        hit_md  ? {16'h0000, mdata_reg} :
        hit_aer ? aer_word :
        hit_uf  ? flags :
        hit_um  ? mask_reg : 32'h0000_0000;

    // ----------------------------------------
    // write data
    // ----------------------------------------
    wire [31:0] xaddr_next  = mcr_merge(xaddr_reg, cfg_req.wdata, cfg_req.be)
                              & `MCR_XADDR_RW;
    wire [31:0] xdata_next  = mcr_merge(xdata_reg, cfg_req.wdata, cfg_req.be);
    wire [31:0] msi_next    = mcr_merge(msi_word, cfg_req.wdata, cfg_req.be);
    // low two address bits never stored
    wire [31:0] maddr_next  = mcr_merge(maddr_reg, cfg_req.wdata, cfg_req.be)
                              & `MCR_MADDR_RW;
    wire [31:0] mupper_next = mcr_merge(mupper_reg, cfg_req.wdata, cfg_req.be);
    wire [31:0] mdata_next  = mcr_merge({16'h0000, mdata_reg}, cfg_req.wdata,
                                        cfg_req.be);
    wire [31:0] mask_next   = mcr_merge(mask_reg, cfg_req.wdata, cfg_req.be)
                              & `MCR_UE_IMPL;
    // ones written to enabled lanes clear flags
    wire [31:0] flag_clr    = (req_wr && hit_uf) ? (cfg_req.wdata & be_mask)
                                                 : 32'h0000_0000;

    // ----------------------------------------
    // non-sticky registers: back to reset values (64-bit indicator to 1, rest zero) on either reset
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xaddr_reg  <= 32'h0000_0000;
            xdata_reg  <= 32'h0000_0000;
            msien_reg  <= 1'b0;
            mme_reg    <= `MCR_MME_RST;
            cap64_reg  <= `MCR_CAP64_RST;
            maddr_reg  <= 32'h0000_0000;
            mupper_reg <= 32'h0000_0000;
            mdata_reg  <= 16'h0000;
        end else if (cfg_soft_rst) begin
            xaddr_reg  <= 32'h0000_0000;
            xdata_reg  <= 32'h0000_0000;
            msien_reg  <= 1'b0;
            mme_reg    <= `MCR_MME_RST;
            cap64_reg  <= `MCR_CAP64_RST;
            maddr_reg  <= 32'h0000_0000;
            mupper_reg <= 32'h0000_0000;
            mdata_reg  <= 16'h0000;
        end else if (req_wr) begin
            if (hit_xa) begin
                xaddr_reg <= xaddr_next;
            end
            if (hit_xd) begin
                xdata_reg <= xdata_next;
            end
            if (hit_msi) begin
                msien_reg <= msi_next[`MCR_MSIEN_BIT];
                mme_reg   <= msi_next[22:20];
                cap64_reg <= msi_next[23];
            end
            if (hit_ma) begin
                maddr_reg <= maddr_next;
            end
            if (hit_mu) begin
                mupper_reg <= mupper_next;
            end
            // only the low half is kept
            if (hit_md) begin
                mdata_reg <= mdata_next[15:0];
            end
        end
    end

    // ----------------------------------------
    // sticky masks: power-on reset only
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= 32'h0000_0000;
        end else if (req_wr && hit_um) begin
            mask_reg <= mask_next;
        end
    end

    mcr_err_flags #(
        .W    (32),
        .IMPL (`MCR_UE_IMPL)
    ) u_flags (
        .core_clk (core_clk),
        .rst      (rst),
        .set_in   (err_event),
        .clr_in   (flag_clr),
        .flag_q   (flags)
    );

    // ----------------------------------------
    // answer and extended access strobes
    // ----------------------------------------
    // answer one cycle after the request; forwarding needs the enable bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            ext_wr_reg    <= 1'b0;
            ext_rd_reg    <= 1'b0;
            ext_wdata_reg <= 32'h0000_0000;
            ext_be_reg    <= 4'h0;
            rep_reg       <= 1'b0;
        end else begin
            ack_reg    <= cfg_req.valid;
            rdata_reg  <= req_rd ? rd_word : 32'h0000_0000;
            ext_wr_reg <= req_wr && hit_xd && xen;
            ext_rd_reg <= req_rd && hit_xd && xen;
            if (req_wr && hit_xd) begin
                ext_wdata_reg <= cfg_req.wdata;
                ext_be_reg    <= cfg_req.be;
            end
            // masked errors are logged but not reported
            rep_reg <= |(err_event & ~mask_reg & `MCR_UE_IMPL);
        end
    end

    assign cfg_ack    = ack_reg;
    assign cfg_rdata  = rdata_reg;
    assign ext_wr     = ext_wr_reg;
    assign ext_rd     = ext_rd_reg;
    assign ext_addr   = xaddr_reg[27:0];
    assign ext_wdata  = ext_wdata_reg;
    assign ext_be     = ext_be_reg;
    assign err_report = rep_reg;

    // ----------------------------------------
    // interrupt path
    // ----------------------------------------
    // pin is asynchronous; a level counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intx_sync_reg <= '1;
            intx_f_reg    <= 1'b1;
        end else begin
            intx_sync_reg <= {intx_sync_reg[1:0], intx_pin_n};
            if (intx_sync_reg[1] == intx_sync_reg[2]) begin
                intx_f_reg <= intx_sync_reg[2];
            end
        end
    end

    // legacy line follows the pin only while messages are off
    // pin ignored once messages are on
    assign intx_out_n = intx_f_reg | msien_reg;

    // message write of stored data to stored address
    mcr_msi_sender u_msi (
        .core_clk  (core_clk),
        .rst       (rst),
        .soft_rst  (cfg_soft_rst),
        .enable    (msien_reg),
        .cap64     (cap64_reg),
        .addr_lo   (maddr_reg),
        .addr_hi   (mupper_reg),
        .data      (mdata_reg),
        .trigger   (irq_event),
        .msi_wr    (msi_wr),
        .msi_valid (msi_valid),
        .msi_ready (msi_ready)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_port_fwd_gate: assert property (@(posedge core_clk) disable iff (rst)
        ext_wr |-> $past(xen) && $past(req_wr && hit_xd))
        else $error("extended write forwarded while disabled");
    chk_rsvd_read_zero: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && (cfg_req.addr == `MCR_OFF_RSV0 || cfg_req.addr == `MCR_OFF_RSV1)
        |=> cfg_ack && cfg_rdata == 32'h0000_0000)
        else $error("reserved offset read nonzero");
    chk_msi_header: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && hit_msi |=> cfg_rdata[15:0] == 16'h0005 && cfg_rdata[31:24] == 8'h00
        && cfg_rdata[19:17] == 3'h0)
        else $error("msi header read wrong");
    chk_no_msg_off: assert property (@(posedge core_clk) disable iff (rst)
        !msien_reg |-> !msi_valid)
        else $error("message sent while disabled");
    chk_intx_masked: assert property (@(posedge core_clk) disable iff (rst)
        msien_reg |-> intx_out_n)
        else $error("legacy line active with messages on");
    chk_addr_aligned: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && hit_ma |=> cfg_rdata[1:0] == 2'b00)
        else $error("message address unaligned");
    chk_data_upper: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && hit_md |=> cfg_rdata[31:16] == 16'h0000)
        else $error("message data upper half nonzero");
    chk_msg_issue: assert property (@(posedge core_clk) disable iff (rst || cfg_soft_rst)
        irq_event && msien_reg && !msi_valid ##1 msien_reg |-> msi_valid
        && msi_wr.data == $past(mdata_reg))
        else $error("interrupt did not start a message");
    chk_aer_header: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && hit_aer |=> cfg_rdata == 32'h1501_0001)
        else $error("error reporting header wrong");
    chk_flag_set_wins: assert property (@(posedge core_clk) disable iff (rst)
        err_event[0] |=> flags[0] ##1 flags[0] || $past(flag_clr[0]))
        else $error("error event lost");
    chk_mask_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        req_rd && hit_um |=> (cfg_rdata & ~32'h001F_F011) == 32'h0000_0000)
        else $error("mask reserved bits nonzero");
endmodule // mcr_cfg_regs

// File: tb/mcr_far_end.sv
// far side model: message write acceptor and extended access target
`timescale 1ns/1ps
module mcr_far_end
    import mcr_pkg::*;
#(
    parameter logic [31:0] RD_PAT = 32'h5A3C_96E1
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // message write channel
    input  wire logic        msi_valid,
    output logic             msi_ready,
    input  wire logic [3:0]  ready_dly,
    // extended access target
    output logic [31:0]      ext_rdata
);
    logic [3:0] wait_reg;

    // count cycles that a message write has stood
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= msi_valid ? wait_reg + 4'h1 : 4'h0;
        end
    end

    // accept only after the chosen stall, so slow hosts get exercised
    assign msi_ready = msi_valid && (wait_reg == ready_dly);
    assign ext_rdata = RD_PAT;
endmodule // mcr_far_end

// File: tb/tb.sv
// self-checking bench for the msi/error config register block
`timescale 1ns/1ps
module tb
    import mcr_pkg::*;
;
    logic            core_clk = 1'b0;
    logic            rst = 1'b1;
    logic            cfg_soft_rst = 1'b0;
    mcr_cfg_req_type cfg_req = '0;
    logic            cfg_ack, ext_wr, ext_rd, intx_out_n, msi_valid, msi_ready;
    logic            err_report, xw, xr;
    logic            irq_event = 1'b0;
    logic            intx_pin_n = 1'b1;
    logic [31:0]     cfg_rdata, ext_wdata, ext_rdata, rd;
    logic [31:0]     err_event = 32'h0;
    logic [27:0]     ext_addr;
    logic [3:0]      ext_be;
    logic [3:0]      dly = 4'h0;
    mcr_msi_wr_type  msi_wr;
    int              error_cnt = 0;
    int              checks_done = 0;
    // offsets and reset values
    logic [11:0] rs_a [10] = '{12'h0E4, 12'h0E8, 12'h0EC, 12'h0F0, 12'h0F4,
                               12'h0F8, 12'h0FC, 12'h100, 12'h104, 12'h108};
    logic [31:0] rs_e [10] = '{32'h0, 32'h0, 32'h0, 32'h0080_0005, 32'h0,
                               32'h0, 32'h0, 32'h1501_0001, 32'h0, 32'h0};

    always #20 core_clk = ~core_clk;

    mcr_cfg_regs u_dut (.core_clk, .rst, .cfg_soft_rst, .cfg_req, .cfg_ack,
        .cfg_rdata, .ext_wr, .ext_rd, .ext_addr, .ext_wdata, .ext_be,
        .ext_rdata, .irq_event, .intx_pin_n, .intx_out_n, .msi_wr,
        .msi_valid, .msi_ready, .err_event, .err_report);
    mcr_far_end u_far (.core_clk, .rst, .msi_valid, .msi_ready,
        .ready_dly(dly), .ext_rdata);

    // --------------------------------------------------
    // access and check tasks
    // --------------------------------------------------
    task automatic chk(input string n, input logic [80:0] e, input logic [80:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask

    // one request, answer sampled after the ack edge settles
    task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cfg_req <= '{1'b1, w, a, 4'hF, d};
        @(posedge core_clk);
        cfg_req.valid <= 1'b0;
        #1;
        rd = cfg_rdata;
        xw = ext_wr;
        xr = ext_rd;
        chk("ack", 1, cfg_ack);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        cfg(1'b0, a, 32'h0);
        chk("rdata", e, rd);
    endtask

    task automatic wrrd(input logic [11:0] a, input logic [31:0] w, input logic [31:0] e);
        cfg(1'b1, a, w);
        rdchk(a, e);
    endtask

    task automatic pulse(input logic [31:0] ev, input logic irq);
        @(posedge core_clk);
        err_event <= ev;
        irq_event <= irq;
        @(posedge core_clk);
        err_event <= 32'h0;
        irq_event <= 1'b0;
        #1;
    endtask

    // bounded wait for the message write to be taken
    task automatic msi_done();
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            #1;
            if (msi_valid !== 1'b1) break;
        end
        chk("msi drop", 0, msi_valid);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // --------------------------------------------------
    // tests
    // --------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rs_a[i]) rdchk(rs_a[i], rs_e[i]);
        $display("test reset done");
        @(posedge core_clk);
        intx_pin_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk("intx", 0, intx_out_n);
        pulse(32'h0, 1'b1);
        chk("msi off", 0, msi_valid);
        // every legal enabled-count code, never the reserved ones
        for (int c = 0; c < 6; c++) begin
            wrrd(12'h0F0, {9'h1FF, c[2:0], 20'hF_FFFF}, {9'h001, c[2:0], 20'h1_0005});
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk("intx", 1, intx_out_n);
        wrrd(12'h0F4, 32'hFFFF_FFFF, 32'hFFFF_FFFC);
        wrrd(12'h0F8, 32'h89AB_CDEF, 32'h89AB_CDEF);
        wrrd(12'h0FC, 32'hFFFF_A5C3, 32'h0000_A5C3);
        $display("test msi regs done");
        dly = 4'h3;
        pulse(32'h0, 1'b1);
        chk("msi on", 1, msi_valid);
        chk("msi wr", {64'h89AB_CDEF_FFFF_FFFC, 16'hA5C3, 1'b1}, msi_wr);
        msi_done();
        wrrd(12'h0F8, 32'h0, 32'h0);
        dly = 4'h0;
        pulse(32'h0, 1'b1);
        chk("msi wr", {64'hFFFF_FFFC, 16'hA5C3, 1'b0}, msi_wr);
        msi_done();
        $display("test msi send done");
        wrrd(12'h0E8, 32'hFFFF_FFFF, 32'h0);
        wrrd(12'h0EC, 32'hFFFF_FFFF, 32'h0);
        cfg(1'b1, 12'h0E4, 32'h1111_2222);
        chk("ext wr", 0, xw);
        rdchk(12'h0E4, 32'h1111_2222);
        cfg(1'b1, 12'h0E0, 32'h8000_0ABC);
        cfg(1'b1, 12'h0E4, 32'h3333_4444);
        chk("ext wr", 1, xw);
        chk("ext data", 32'h3333_4444, ext_wdata);
        chk("ext addr", 28'h0000_ABC, ext_addr);
        chk("ext be", 4'hF, ext_be);
        rdchk(12'h0E4, 32'h5A3C_96E1);
        chk("ext rd", 1, xr);
        cfg(1'b1, 12'h0E0, 32'h0);
        $display("test ext port done");
        wrrd(12'h108, 32'hFFFF_FFFF, 32'h001F_F011);
        pulse(32'hFFFF_FFFF, 1'b0);
        chk("report", 0, err_report);
        rdchk(12'h104, 32'h001F_F011);
        wrrd(12'h104, 32'h0000_1000, 32'h001F_E011);
        @(posedge core_clk);
        cfg_soft_rst <= 1'b1;
        @(posedge core_clk);
        cfg_soft_rst <= 1'b0;
        rdchk(12'h104, 32'h001F_E011);
        rdchk(12'h108, 32'h001F_F011);
        rdchk(12'h0F4, 32'h0);
        wrrd(12'h108, 32'h0, 32'h0);
        pulse(32'h0000_2000, 1'b0);
        chk("report", 1, err_report);
        $display("test errors done");
        // power-on reset mid-run clears even the sticky flags and masks
        wrrd(12'h108, 32'h0000_0010, 32'h0000_0010);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(12'h104, 32'h0);
        rdchk(12'h108, 32'h0);
        rdchk(12'h0F0, 32'h0080_0005);
        $display("test power reset done");
        stop_test();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        stop_test();
    end
endmodule // tb
